// File: logic/hulr_defs.svh
// Offsets, field positions, reset values and timing counts of the host serial port registers
// How it works
// - Divisor access select high maps offsets 0 and 1 onto the divisor bytes.
// - Break control forces the transmit line to space; receive logic unaffected.
// - Fixed parity sends and checks 0 when even select set, else 1.
// - Normal parity makes data plus parity ones even or odd per even select.
// - Parity enable adds a parity bit between last data bit and stop.
// - Stop select gives one or two stop bits; receiver checks only the first.
// - Length code 10 gives 7 data bits, 11 gives 8 data bits.
// - Loopback returns transmitted characters into the receive buffer internally.
// - Loopback feeds modem status from terminal-ready, request-to-send and user outputs.
// - User output two enables the host interrupt driver, else it floats.
// - Control bits 1 and 0 switch request-to-send and terminal-ready outputs; loopback holds both outputs low.
// - FIFO error flag holds while any queued character is bad, then until the next status read; reads 0 without FIFO.
// - Transmitter idle only when holding buffer and shifter are both empty.
// - Holding empty sets when buffer drains to shifter, clears on host write.
// - Break flag sets after space longer than two characters plus three bits.
// - Framing fault sets on a space first stop bit, shown with its character.
// - Parity fault sets on failed parity check, shown with its character.
// - Overrun sets when a character arrives with no room left.
// - Data ready sets when a character is buffered, clears on buffer read.
// - Change bits set on input change, clear on status read or reset.
// - Ring change bit sets only on a one to zero transition.
// - Characters go least significant bit first on the line.
// - FIFO control bits act only with enable bit one; zero clears both FIFOs.
// - Trigger code selects receive threshold of 1, 4, 8 or 14 bytes.
`ifndef HULR_DEFS_SVH
`define HULR_DEFS_SVH

// ********************
// Register offsets
// ********************
`define HULR_OFS_DATA 3'h0
`define HULR_OFS_IER  3'h1
`define HULR_OFS_FCR  3'h2
`define HULR_OFS_LCR  3'h3
`define HULR_OFS_MCR  3'h4
`define HULR_OFS_LSR  3'h5
`define HULR_OFS_MSR  3'h6
`define HULR_OFS_SCR  3'h7

// ********************
// Field positions
// ********************
`define HULR_LCR_DIVISOR_ACCESS_SELECT   7
`define HULR_LCR_BREAK  6
`define HULR_LCR_FIXED  5
`define HULR_LCR_EVEN   4
`define HULR_LCR_PAR    3
`define HULR_LCR_STOP   2
`define HULR_MCR_LOOP   4
`define HULR_MCR_USER_OUTPUT_TWO   3
`define HULR_MCR_USER_OUTPUT_ONE   2
`define HULR_MCR_RTS    1
`define HULR_MCR_DTR    0

// ********************
// Reset values and timing
// ********************
`define HULR_DIV_RESET  16'h000C
`define HULR_CLK_HZ     25000000
`define HULR_REF_HZ     1843200
`define HULR_CLK_STEP   (`HULR_CLK_HZ / 100)
`define HULR_REF_STEP   (`HULR_REF_HZ / 100)
`define HULR_BIT_LAST   15
`define HULR_BIT_MID    7
`define HULR_STOP1_LAST 15
`define HULR_STOP2_LAST 31
`define HULR_BRK_EXTRA  48
`define HULR_TRIG0      1
`define HULR_TRIG1      4
`define HULR_TRIG2      8
`define HULR_TRIG3      14

`endif

// File: logic/hulr_pkg.sv
// Types shared by the host serial port logic
package hulr_pkg;
  typedef enum logic [4:0] {
    HULR_TX_IDLE  = 5'b00001,
    HULR_TX_START = 5'b00010,
    HULR_TX_DATA  = 5'b00100,
    HULR_TX_PAR   = 5'b01000,
    HULR_TX_STOP  = 5'b10000
  } hulr_tx_e;
  typedef enum logic [4:0] {
    HULR_RX_IDLE  = 5'b00001,
    HULR_RX_START = 5'b00010,
    HULR_RX_DATA  = 5'b00100,
    HULR_RX_PAR   = 5'b01000,
    HULR_RX_STOP  = 5'b10000
  } hulr_rx_e;
endpackage : hulr_pkg

// File: logic/hulr_top.sv
// Host serial port: register set, FIFOs, transmitter, receiver and modem status
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`include "hulr_defs.svh"
module hulr_top
  import hulr_pkg::*;
#(
  parameter int          DEPTH     = 16,
  parameter logic [15:0] DIV_RESET = `HULR_DIV_RESET
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic      [7:0] rdata_o,
  input  wire logic       rx_i,
  output logic            tx_o,
  input  wire logic       cts_i,
  input  wire logic       dsr_i,
  input  wire logic       ri_i,
  input  wire logic       dcd_i,
  output logic            rts_o,
  output logic            dtr_o,
  output logic            host_int_o,
  output logic            host_int_oe_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [7:0]              line_format_control;
    logic [4:0]              modem_output_control;
    logic [3:0]              ier;
    logic [7:0]              host_scratchpad;
    logic [15:0]             div;
    logic                    fen;
    logic [1:0]              trig;
    logic [17:0]             acc;
    logic [15:0]             dcnt;
    logic [DEPTH-1:0][10:0]  rxm;
    logic [AW-1:0]           rrd;
    logic [AW-1:0]           rwr;
    logic [AW:0]             rcnt;
    logic [DEPTH-1:0][7:0]   txm;
    logic [AW-1:0]           trd;
    logic [AW-1:0]           twr;
    logic [AW:0]             tcnt;
    hulr_tx_e                ts;
    logic [7:0]              tsh;
    logic                    tpar;
    logic [4:0]              tt;
    logic [2:0]              tb;
    logic                    tline;
    hulr_rx_e                rs;
    logic [3:0]              rt;
    logic [2:0]              rb;
    logic [7:0]              rsh;
    logic                    rpar;
    logic                    rperr;
    logic [9:0]              bcnt;
    logic                    bi;
    logic                    fe;
    logic                    pe;
    logic                    oe;
    logic                    ferr;
    logic                    shown;
    logic [3:0]              mprev;
    logic [3:0]              mdelta;
    logic [1:0]              rxs;
    logic [3:0]              ms1;
    logic [3:0]              ms2;
    logic [7:0]              rdata;
    logic                    txo;
    logic                    rts;
    logic                    dtr;
    logic                    host_interrupt_out;
  } hulr_state_s;

  hulr_state_s      r;
  hulr_state_s      n;
  logic             tick;
  logic             rtick;
  logic [18:0]      asum;
  logic [3:0]       nb;
  logic [3:0]       cbits;
  logic [4:0]       stop_last;
  logic [9:0]       bthr;
  logic             rin;
  logic [3:0]       mst;
  logic [7:0]       rdat;
  logic [7:0]       dmask;
  logic [7:0]       rword;
  logic [10:0]      rchar;
  logic             push;
  logic             divisor_access_select;
  logic             rd_rbr;
  logic             rd_lsr;
  logic             rd_msr;
  logic             wr_thr;
  logic [AW:0]      rlim;
  logic [AW:0]      tlevel;
  logic [DEPTH-1:0] qerr;
  logic [7:0]       line_state;
  logic [2:0]       iid;
  logic             pls;
  logic             prx;
  logic             ptx;
  logic             pms;

  // ********************
  // Queued error scan
  // ********************
  for (genvar i = 0; i < DEPTH; i++) begin : g_qerr
    assign qerr[i] = ({1'b0, AW'(AW'(i) - r.rrd)} < r.rcnt) && (|r.rxm[i][10:8]);
  end

  assign divisor_access_select   = r.line_format_control[`HULR_LCR_DIVISOR_ACCESS_SELECT];
  assign rd_rbr = re_i && addr_i == `HULR_OFS_DATA && !divisor_access_select;
  assign wr_thr = we_i && addr_i == `HULR_OFS_DATA && !divisor_access_select;
  assign rd_lsr = re_i && addr_i == `HULR_OFS_LSR;
  assign rd_msr = re_i && addr_i == `HULR_OFS_MSR;
  assign rin    = r.modem_output_control[`HULR_MCR_LOOP] ? r.tline : r.rxs[1];
  assign mst    = r.modem_output_control[`HULR_MCR_LOOP] ? {r.modem_output_control[`HULR_MCR_USER_OUTPUT_TWO], r.modem_output_control[`HULR_MCR_USER_OUTPUT_ONE],
                  r.modem_output_control[`HULR_MCR_DTR], r.modem_output_control[`HULR_MCR_RTS]} : r.ms2;
  assign nb     = (r.line_format_control[1] & r.line_format_control[0]) ? 4'h8 : 4'h7;
  assign cbits  = 4'h1 + nb + {3'h0, r.line_format_control[`HULR_LCR_PAR]} + (r.line_format_control[`HULR_LCR_STOP] ? 4'h2 : 4'h1);
  assign bthr   = 10'({cbits, 5'h00}) + 10'(`HULR_BRK_EXTRA);
  assign stop_last = r.line_format_control[`HULR_LCR_STOP] ? 5'(`HULR_STOP2_LAST) : 5'(`HULR_STOP1_LAST);
  assign dmask  = (nb == 4'h8) ? 8'hFF : 8'h7F;
  assign rword  = (nb == 4'h8) ? r.rsh : {1'b0, r.rsh[7:1]};
  assign rlim   = r.fen ? FULL : (AW+1)'(1);
  assign line_state    = {r.ferr & r.fen, (r.tcnt == '0) && (r.ts == HULR_TX_IDLE), r.tcnt == '0,
                   r.bi, r.fe, r.pe, r.oe, r.rcnt != '0};

  always_comb begin
    case (r.trig)
      2'h0:    tlevel = (AW+1)'(`HULR_TRIG0);
      2'h1:    tlevel = (AW+1)'(`HULR_TRIG1);
      2'h2:    tlevel = (AW+1)'(`HULR_TRIG2);
      default: tlevel = (AW+1)'(`HULR_TRIG3);
    endcase
  end

  assign pls = r.ier[2] & (r.oe | r.pe | r.fe | r.bi);
  assign prx = r.ier[0] & (r.fen ? (r.rcnt >= tlevel) : (r.rcnt != '0));
  assign ptx = r.ier[1] & line_state[5];
  assign pms = r.ier[3] & (|r.mdelta);
  assign iid = pls ? 3'h3 : prx ? 3'h2 : ptx ? 3'h1 : 3'h0;

  always_comb begin
    n     = r;
    tick  = 1'b0;
    rtick = 1'b0;
    push  = 1'b0;
    rchar = '0;
    rdat  = 8'h00;
    // ********************
    // Baud generation
    // ********************
    // Fractional accumulator models the reference clock from the system clock
    asum = {1'b0, r.acc} + 19'(`HULR_REF_STEP);
    if (asum >= 19'(`HULR_CLK_STEP)) begin
      n.acc = 18'(asum - 19'(`HULR_CLK_STEP));
      rtick = 1'b1;
    end else begin
      n.acc = asum[17:0];
    end
    // Divisor of zero behaves as one
    if (rtick) begin
      if (r.dcnt + 16'h0001 >= r.div) begin
        n.dcnt = '0;
        tick   = 1'b1;
      end else begin
        n.dcnt = r.dcnt + 16'h0001;
      end
    end
    n.rxs = {r.rxs[0], rx_i};
    n.ms1 = {dcd_i, ri_i, dsr_i, cts_i};
    n.ms2 = r.ms1;
    // ********************
    // Transmitter
    // ********************
    if (tick) begin
      case (r.ts)
        HULR_TX_IDLE: begin
          if (r.tcnt != '0) begin
            n.tsh  = r.txm[r.trd] & dmask;
            n.tpar = r.line_format_control[`HULR_LCR_FIXED] ? ~r.line_format_control[`HULR_LCR_EVEN] :
                     (r.line_format_control[`HULR_LCR_EVEN] ? ^(r.txm[r.trd] & dmask) : ~^(r.txm[r.trd] & dmask));
            n.trd   = r.trd + 1'b1;
            n.tcnt  = r.tcnt - 1'b1;
            n.ts    = HULR_TX_START;
            n.tt    = '0;
            n.tline = 1'b0;
          end
        end
        HULR_TX_START: begin
          n.tt = r.tt + 5'h01;
          if (r.tt == 5'(`HULR_BIT_LAST)) begin
            n.ts    = HULR_TX_DATA;
            n.tt    = '0;
            n.tb    = '0;
            n.tline = r.tsh[0];
          end
        end
        HULR_TX_DATA: begin
          n.tt = r.tt + 5'h01;
          if (r.tt == 5'(`HULR_BIT_LAST)) begin
            n.tt = '0;
            if ({1'b0, r.tb} == nb - 4'h1) begin
              n.ts    = r.line_format_control[`HULR_LCR_PAR] ? HULR_TX_PAR : HULR_TX_STOP;
              n.tline = r.line_format_control[`HULR_LCR_PAR] ? r.tpar : 1'b1;
            end else begin
              n.tb    = r.tb + 3'h1;
              n.tsh   = {1'b0, r.tsh[7:1]};
              n.tline = r.tsh[1];
            end
          end
        end
        HULR_TX_PAR: begin
          n.tt = r.tt + 5'h01;
          if (r.tt == 5'(`HULR_BIT_LAST)) begin
            n.ts    = HULR_TX_STOP;
            n.tt    = '0;
            n.tline = 1'b1;
          end
        end
        HULR_TX_STOP: begin
          n.tt = r.tt + 5'h01;
          if (r.tt == stop_last) begin
            n.ts = HULR_TX_IDLE;
          end
        end
        default: begin
          n.ts    = HULR_TX_IDLE;
          n.tline = 1'b1;
        end
      endcase
    end
    // ********************
    // Receiver
    // ********************
    if (tick) begin
      case (r.rs)
        HULR_RX_IDLE: begin
          if (!rin) begin
            n.rs = HULR_RX_START;
            n.rt = '0;
          end
        end
        HULR_RX_START: begin
          n.rt = r.rt + 4'h1;
          // Glitch shorter than half a bit is not a start
          if (r.rt == 4'(`HULR_BIT_MID)) begin
            n.rs    = rin ? HULR_RX_IDLE : HULR_RX_DATA;
            n.rt    = '0;
            n.rb    = '0;
            n.rpar  = 1'b0;
            n.rperr = 1'b0;
          end
        end
        HULR_RX_DATA: begin
          n.rt = r.rt + 4'h1;
          if (r.rt == 4'(`HULR_BIT_LAST)) begin
            n.rsh  = {rin, r.rsh[7:1]};
            n.rpar = r.rpar ^ rin;
            if ({1'b0, r.rb} == nb - 4'h1) begin
              n.rs = r.line_format_control[`HULR_LCR_PAR] ? HULR_RX_PAR : HULR_RX_STOP;
            end else begin
              n.rb = r.rb + 3'h1;
            end
          end
        end
        HULR_RX_PAR: begin
          n.rt = r.rt + 4'h1;
          if (r.rt == 4'(`HULR_BIT_LAST)) begin
            n.rperr = r.line_format_control[`HULR_LCR_FIXED] ? (rin == r.line_format_control[`HULR_LCR_EVEN]) :
                      (r.line_format_control[`HULR_LCR_EVEN] ? (r.rpar ^ rin) : ~(r.rpar ^ rin));
            n.rs = HULR_RX_STOP;
          end
        end
        HULR_RX_STOP: begin
          n.rt = r.rt + 4'h1;
          if (r.rt == 4'(`HULR_BIT_LAST)) begin
            push  = 1'b1;
            rchar = {~rin & (rword == 8'h00), ~rin, r.rperr, rword};
            n.rs  = HULR_RX_IDLE;
          end
        end
        default: n.rs = HULR_RX_IDLE;
      endcase
      if (rin) begin
        n.bcnt = '0;
      end else if (r.bcnt != 10'h3FF) begin
        n.bcnt = r.bcnt + 10'h001;
      end
    end
    // ********************
    // Host reads
    // ********************
    if (rd_lsr) begin
      n.bi = 1'b0;
      n.fe = 1'b0;
      n.pe = 1'b0;
      n.oe = 1'b0;
    end
    if (rd_msr) begin
      n.mdelta = 4'h0;
    end
    // Each character reports its faults once when it becomes the buffer head
    if (r.rcnt != '0 && !r.shown) begin
      n.fe    = n.fe | r.rxm[r.rrd][9];
      n.pe    = n.pe | r.rxm[r.rrd][8];
      n.shown = 1'b1;
    end
    if (rd_rbr && r.rcnt != '0) begin
      n.rrd   = r.rrd + 1'b1;
      n.rcnt  = r.rcnt - 1'b1;
      n.shown = 1'b0;
    end
    if (push) begin
      if (n.rcnt >= rlim) begin
        n.oe = 1'b1;
        // Without FIFO the newest character replaces the unread one
        if (!r.fen) begin
          n.rxm[r.rrd] = rchar;
          n.shown      = 1'b0;
        end
      end else begin
        n.rxm[n.rwr] = rchar;
        n.rwr        = n.rwr + 1'b1;
        n.rcnt       = n.rcnt + 1'b1;
      end
    end
    if (tick && !rin && r.bcnt == bthr) begin
      n.bi = 1'b1;
    end
    n.mprev  = mst;
    n.mdelta = n.mdelta | {mst[3] ^ r.mprev[3], r.mprev[2] & ~mst[2],
                           mst[1] ^ r.mprev[1], mst[0] ^ r.mprev[0]};
    n.ferr = r.fen & ((|qerr) | (r.ferr & ~rd_lsr));
    // ********************
    // Host writes
    // ********************
    if (wr_thr && n.tcnt < rlim) begin
      n.txm[r.twr] = wdata_i;
      n.twr        = r.twr + 1'b1;
      n.tcnt       = n.tcnt + 1'b1;
    end
    if (we_i) begin
      case (addr_i)
        `HULR_OFS_DATA: if (divisor_access_select) n.div[7:0] = wdata_i;
        `HULR_OFS_IER: begin
          if (divisor_access_select) begin
            n.div[15:8] = wdata_i;
          end else begin
            n.ier = wdata_i[3:0];
          end
        end
        `HULR_OFS_FCR: begin
          n.fen = wdata_i[0];
          if (wdata_i[0]) begin
            n.trig = wdata_i[7:6];
          end
          if (!wdata_i[0] || !r.fen || wdata_i[1]) begin
            n.rrd  = '0;
            n.rwr  = '0;
            n.rcnt = '0;
            n.ferr = 1'b0;
          end
          if (!wdata_i[0] || !r.fen || wdata_i[2]) begin
            n.trd  = '0;
            n.twr  = '0;
            n.tcnt = '0;
          end
        end
        `HULR_OFS_LCR: n.line_format_control = wdata_i;
        `HULR_OFS_MCR: n.modem_output_control = wdata_i[4:0];
        `HULR_OFS_SCR: n.host_scratchpad = wdata_i;
        default: ;
      endcase
    end
    // ********************
    // Read data and outputs
    // ********************
    case (addr_i)
      `HULR_OFS_DATA: rdat = divisor_access_select ? r.div[7:0] : (r.rcnt != '0 ? r.rxm[r.rrd][7:0] : 8'h00);
      `HULR_OFS_IER:  rdat = divisor_access_select ? r.div[15:8] : {4'h0, r.ier};
      `HULR_OFS_FCR:  rdat = {r.fen, r.fen, 2'h0, iid, ~(pls | prx | ptx | pms)};
      `HULR_OFS_LCR:  rdat = r.line_format_control;
      `HULR_OFS_MCR:  rdat = {3'h0, r.modem_output_control};
      `HULR_OFS_LSR:  rdat = line_state;
      `HULR_OFS_MSR:  rdat = {mst, r.mdelta};
      default:        rdat = r.host_scratchpad;
    endcase
    n.rdata = re_i ? rdat : 8'h00;
    // Line held at mark toward the pins during loopback unless break is set
    n.txo  = ~n.line_format_control[`HULR_LCR_BREAK] & (n.modem_output_control[`HULR_MCR_LOOP] | n.tline);
    n.rts  = n.modem_output_control[`HULR_MCR_RTS] & ~n.modem_output_control[`HULR_MCR_LOOP];
    n.dtr  = n.modem_output_control[`HULR_MCR_DTR] & ~n.modem_output_control[`HULR_MCR_LOOP];
    n.host_interrupt_out = pls | prx | ptx | pms;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r       <= '0;
      r.div   <= DIV_RESET;
      r.ts    <= HULR_TX_IDLE;
      r.rs    <= HULR_RX_IDLE;
      r.tline <= 1'b1;
      r.txo   <= 1'b1;
      r.rxs   <= 2'h3;
    end else begin
      r <= n;
    end
  end

  assign rdata_o       = r.rdata;
  assign tx_o          = r.txo;
  assign rts_o         = r.rts;
  assign dtr_o         = r.dtr;
  assign host_int_o    = r.host_interrupt_out;
  assign host_int_oe_o = r.modem_output_control[`HULR_MCR_USER_OUTPUT_TWO];

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_div_read;
    re_i && addr_i == `HULR_OFS_DATA && divisor_access_select;
  endsequence
  sequence seq_msr_loop_read;
    rd_msr && r.modem_output_control[`HULR_MCR_LOOP];
  endsequence

  AST_DIV_READ: assert property (seq_div_read |=> rdata_o == $past(r.div[7:0]))
    else $error("divisor low byte not returned");
  AST_BREAK_TX: assert property (r.line_format_control[`HULR_LCR_BREAK] |-> !tx_o)
    else $error("break not forcing space");
  AST_LOOP_MSR: assert property (seq_msr_loop_read |=> rdata_o[7:4] == $past({r.modem_output_control[3], r.modem_output_control[2],
                                 r.modem_output_control[0], r.modem_output_control[1]}))
    else $error("loopback status mapping wrong");
  AST_INT_OE: assert property (we_i && addr_i == `HULR_OFS_MCR |=> host_int_oe_o == $past(wdata_i[3]))
    else $error("interrupt enable drive mismatch");
  AST_MODEM_OUT: assert property (we_i && addr_i == `HULR_OFS_MCR && !wdata_i[`HULR_MCR_LOOP] |=>
                                  rts_o == $past(wdata_i[1]) && dtr_o == $past(wdata_i[0]))
    else $error("modem control outputs wrong");
  AST_NOFIFO_ERR: assert property (rd_lsr && !r.fen |=> !rdata_o[7])
    else $error("fifo error seen outside fifo mode");
  AST_TRANSMITTER_IDLE: assert property (rd_lsr && (r.ts != HULR_TX_IDLE || r.tcnt != '0) |=> !rdata_o[6])
    else $error("idle flag while shifting");
  AST_TX_HOLDING_EMPTY_CLR: assert property (wr_thr && r.tcnt == '0 |=> !line_state[5])
    else $error("holding empty not cleared by write");
  AST_BREAK_SET: assert property (tick && !rin && r.bcnt == bthr |=> r.bi)
    else $error("break flag not set");
  AST_DR_CLR: assert property (rd_rbr && r.rcnt == (AW+1)'(1) && !push |=> !line_state[0])
    else $error("data ready not cleared by read");
  AST_MSR_CLR: assert property (rd_msr && mst == r.mprev |=> r.mdelta == 4'h0)
    else $error("change bits not cleared by read");
endmodule : hulr_top

// File: tb/hulr_line_partner.sv
// Serial line partner: sends frames into the port and captures its frames
`timescale 1ns/1ns
module hulr_line_partner #(
  parameter int BIT_NS = 8681
) (
  input  wire logic tx_i,
  output logic      rx_o
);
  logic [9:0] cap;
  int         frames;
  initial begin
    rx_o   = 1'b1;
    frames = 0;
    cap    = '0;
  end
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    rx_o = 1'b0;
    #(BIT_NS);
    for (int j = 0; j < 8; j++) begin
      rx_o = d[j];
      #(BIT_NS);
    end
    rx_o = p;
    #(BIT_NS);
    rx_o = s;
    #(BIT_NS);
    rx_o = 1'b1;
    #(2 * BIT_NS);
  endtask : send
  task automatic hold_space(input int n);
    rx_o = 1'b0;
    #(n * BIT_NS);
    rx_o = 1'b1;
    #(2 * BIT_NS);
  endtask : hold_space
  // Bit centres after the start bit; 7-bit frames run into the idle mark
  always @(negedge tx_i) begin
    #(BIT_NS / 2);
    if (tx_i == 1'b0) begin
      for (int j = 0; j < 10; j++) begin
        #(BIT_NS);
        cap[j] = tx_i;
      end
      frames++;
    end
  end
endmodule : hulr_line_partner

// File: tb/hulr_top_tb_top.sv
// Testbench for the host serial port register set
`timescale 1ns/1ns
`define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, ac); end end
module hulr_top_tb_top;
  import hulr_pkg::*;
  typedef struct packed {logic we; logic [2:0] a; logic [7:0] d;} hulr_row_s;
  logic       clk_i, rst_i, we_i, re_i, cts_i, dsr_i, ri_i, dcd_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i, rd_v, rdata_o;
  logic       rx_w, tx_o, rts_o, dtr_o, host_int_o, host_int_oe_o;
  int         err_count = 0;
  int         checked   = 0;
  hulr_row_s  rows[17] = '{
    '{0,3'h3,8'h00}, '{0,3'h4,8'h00}, '{0,3'h5,8'h60}, '{0,3'h6,8'h00}, '{1,3'h7,8'hA5},
    '{0,3'h7,8'hA5}, '{1,3'h5,8'hFF}, '{0,3'h5,8'h60}, '{1,3'h3,8'h83}, '{0,3'h0,8'h0C},
    '{1,3'h0,8'h01}, '{1,3'h1,8'h00}, '{0,3'h0,8'h01}, '{0,3'h1,8'h00}, '{1,3'h3,8'h1B},
    '{0,3'h3,8'h1B}, '{0,3'h0,8'h00}};
  logic [7:0] lcr_t[5] = '{8'h1B, 8'h0B, 8'h3B, 8'h2B, 8'h1A};
  logic [9:0] cap_t[5] = '{10'h2A6, 10'h3A6, 10'h2A6, 10'h3A6, 10'h3A6};

  hulr_top #(.DEPTH(16), .DIV_RESET(16'h000C)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .rx_i(rx_w), .tx_o(tx_o), .cts_i(cts_i), .dsr_i(dsr_i),
    .ri_i(ri_i), .dcd_i(dcd_i), .rts_o(rts_o), .dtr_o(dtr_o), .host_int_o(host_int_o),
    .host_int_oe_o(host_int_oe_o));
  hulr_line_partner lp (.tx_i(tx_o), .rx_o(rx_w));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd
  task automatic poll(input int b, output logic [7:0] v);
    for (int n = 0; n < 4000; n++) begin
      rd(3'h5, v);
      if (v[b] === 1'b1) break;
    end
  endtask : poll
  task automatic wait_frame(input int n);
    for (int c = 0; c < 5000 && lp.frames < n; c++) @(posedge clk_i);
    `CHK("frame count", n, lp.frames)
  endtask : wait_frame

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Whole run is near 1.3 ms of line time
  initial begin
    #3_500_000;
    err_count++;
    stop_test();
  end
  initial begin
    {rst_i, we_i, re_i, cts_i, dsr_i, ri_i, dcd_i} = 7'h40;
    addr_i  = '0;
    wdata_i = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      if (rows[i].we) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, rd_v);
        `CHK("register", rows[i].d, rd_v)
      end
    end
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      wr(3'h3, lcr_t[i]);
      wr(3'h0, 8'hA6);
      rd(3'h5, rd_v);
      `CHK("tx idle", 1'b0, rd_v[6])
      wait_frame(i + 1);
      `CHK("tx frame", cap_t[i], lp.cap)
    end
    $display("test transmit formats done");
    wr(3'h3, 8'h1B);
    lp.send(8'h3C, 1'b1, 1'b1);
    poll(0, rd_v);
    `CHK("parity state", 8'h65, rd_v)
    rd(3'h0, rd_v);
    `CHK("rx data", 8'h3C, rd_v)
    lp.send(8'hC3, 1'b0, 1'b0);
    poll(0, rd_v);
    `CHK("framing state", 8'h69, rd_v)
    rd(3'h0, rd_v);
    `CHK("rx data", 8'hC3, rd_v)
    lp.hold_space(32);
    poll(4, rd_v);
    `CHK("break flag", 1'b1, rd_v[4])
    `CHK("overrun", 1'b1, rd_v[1])
    rd(3'h0, rd_v);
    `CHK("break char", 8'h00, rd_v)
    $display("test receive errors done");
    wr(3'h3, 8'h5B);
    repeat (3) @(posedge clk_i);
    `CHK("break out", 1'b0, tx_o)
    wr(3'h3, 8'h1B);
    $display("test break out done");
    wr(3'h4, 8'h1F);
    rd(3'h6, rd_v);
    `CHK("loop status", 8'hFB, rd_v)
    `CHK("int enable", 1'b1, host_int_oe_o)
    wr(3'h4, 8'h1B);
    rd(3'h6, rd_v);
    `CHK("ring trailing", 8'hB4, rd_v)
    wr(3'h0, 8'h5A);
    poll(0, rd_v);
    rd(3'h0, rd_v);
    `CHK("loop data", 8'h5A, rd_v)
    wr(3'h4, 8'h03);
    repeat (4) @(posedge clk_i);
    `CHK("rts dtr", 2'b11, {rts_o, dtr_o})
    `CHK("int float", 1'b0, host_int_oe_o)
    $display("test loopback done");
    rd(3'h6, rd_v);
    @(posedge clk_i);
    cts_i <= 1'b1;
    ri_i  <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(3'h6, rd_v);
    `CHK("modem rise", 8'h51, rd_v)
    @(posedge clk_i);
    ri_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(3'h6, rd_v);
    `CHK("modem fall", 8'h14, rd_v)
    wr(3'h1, 8'h08);
    @(posedge clk_i);
    cts_i <= 1'b0;
    dsr_i <= 1'b1;
    dcd_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("modem int", 1'b1, host_int_o)
    rd(3'h6, rd_v);
    `CHK("modem all", 8'hAB, rd_v)
    repeat (2) @(posedge clk_i);
    `CHK("modem int clear", 1'b0, host_int_o)
    $display("test modem inputs done");
    // Second byte would be dropped without the queue
    wr(3'h2, 8'h01);
    wr(3'h4, 8'h18);
    wr(3'h0, 8'h11);
    wr(3'h0, 8'h22);
    repeat (6000) @(posedge clk_i);
    rd(3'h5, rd_v);
    `CHK("fifo state", 8'h61, rd_v)
    rd(3'h0, rd_v);
    `CHK("fifo first", 8'h11, rd_v)
    rd(3'h0, rd_v);
    `CHK("fifo second", 8'h22, rd_v)
    $display("test fifo done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(3'h3, rd_v);
    `CHK("reset format", 8'h00, rd_v)
    `CHK("reset line", 1'b1, tx_o)
    `CHK("reset int oe", 1'b0, host_int_oe_o)
    wr(3'h3, 8'h80);
    rd(3'h0, rd_v);
    `CHK("reset divisor", 8'h0C, rd_v)
    rd(3'h5, rd_v);
    `CHK("reset state", 8'h60, rd_v)
    $display("test reset done");
    stop_test();
  end
endmodule : hulr_top_tb_top
